// ===== usu_defines.svh
// Offsets, field positions, reset values and timing counts of the serial shift unit
`ifndef USU_DEFINES_SVH
`define USU_DEFINES_SVH
`define USU_OFF_DATA 8'h00
`define USU_OFF_STATUS 8'h04
`define USU_OFF_CTRL 8'h08
`define USU_OFF_PINS 8'h0C
`define USU_ST_SIF 7
`define USU_ST_OIF 6
`define USU_ST_PF 5
`define USU_ST_DC 4
`define USU_ST_CNT_HI 3
`define USU_ST_CNT_LO 0
`define USU_CT_SIE 7
`define USU_CT_OIE 6
`define USU_CT_WM_HI 5
`define USU_CT_WM_LO 4
`define USU_CT_CS_HI 3
`define USU_CT_CS_LO 2
`define USU_CT_STROBE 1
`define USU_CT_TOGGLE 0
`define USU_PN_PORT_SDA 0
`define USU_PN_PORT_SCL 1
`define USU_PN_PORT_DO 2
`define USU_PN_DDR_SDA 4
`define USU_PN_DDR_SCL 5
`define USU_PN_DDR_DO 6
`define USU_WM_OFF 2'h0
`define USU_WM_THREE 2'h1
`define USU_WM_TWO 2'h2
`define USU_RST_DATA 8'h00
`define USU_RST_CNT 4'h0
`define USU_RST_CTRL 8'h00
`define USU_RST_PINS 8'h00
`define USU_CNT_MAX 4'hF
`define USU_RESP_OKAY 2'h0
`define USU_RESP_SLVERR 2'h2
`define USU_CLK_NS 8
`define USU_SDA_DLY_NS 50
`define USU_SDA_DLY_CYC ((`USU_SDA_DLY_NS + `USU_CLK_NS - 1) / `USU_CLK_NS)
`endif

// ===== usu_pkg.sv
// Types shared by the serial shift unit files
`include "usu_defines.svh"
package usu_pkg;
    typedef struct packed {
        logic awvalid;
        logic [31:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [31:0] araddr;
        logic rready;
    } usu_axi_req_type;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } usu_axi_rsp_type;
    typedef struct packed {
        logic serial_in;
        logic serial_clock;
    } usu_pin_in_type;
    typedef struct packed {
        logic sda_out;
        logic sda_oe_n;
        logic scl_out;
        logic scl_oe_n;
        logic data_out;
        logic data_oe_n;
    } usu_pin_out_type;
    typedef struct packed {
        logic [1:0] meta;
        logic [1:0] sync;
    } usu_sync_type;
    typedef struct packed {
        logic [7:0] data;
        logic [3:0] cnt;
        logic sif;
        logic oif;
        logic pf;
        logic sie;
        logic oie;
        logic [1:0] wm;
        logic [1:0] cs;
        logic port_sda;
        logic port_scl;
        logic port_do;
        logic ddr_sda;
        logic ddr_scl;
        logic ddr_do;
        logic shold;
        logic ohold;
        logic latch;
        logic scl_prev;
        logic [`USU_SDA_DLY_CYC:0] sda_dly;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [7:0] wdata;
        logic wlane;
        usu_axi_rsp_type axi;
        usu_pin_out_type pins;
        logic start_irq;
        logic ovf_irq;
    } usu_state_type;
endpackage

// ===== usu_sync.sv
// Two-stage synchroniser for the two serial pins
`timescale 1ns/1ns
`default_nettype none
module usu_sync (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [1:0] async_in,
    output logic [1:0] sync_out
);
    import usu_pkg::*;
    usu_sync_type s_q;
    usu_sync_type s_d;

    always_comb begin
        s_d = s_q;
        s_d.meta = async_in;
        s_d.sync = s_q.meta;
    end

    // Idle bus lines are high, so reset to released
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_q <= '{meta: 2'h3, sync: 2'h3};
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.sync;
endmodule
`default_nettype wire

// ===== usu_top.sv
// Serial shift unit with two-wire start/stop detection and clock hold, on AXI4-Lite
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ns
`default_nettype none
module usu_top (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire usu_pkg::usu_axi_req_type axi_in,
    output usu_pkg::usu_axi_rsp_type axi_out,
    input wire usu_pkg::usu_pin_in_type pins_in,
    output usu_pkg::usu_pin_out_type pins_out,
    input wire logic timer_match_in,
    output logic start_irq_out,
    output logic ovf_irq_out
);
    import usu_pkg::*;

    usu_state_type s_q;
    usu_state_type s_d;
    logic [1:0] pin_sync;
    logic sda_s;
    logic scl_s;
    logic two_wire;
    logic ext_clk;
    logic scl_rise;
    logic scl_fall;
    logic sda_dly_now;
    logic sda_dly_old;
    logic start_det;
    logic stop_det;
    logic cnt_inc;
    logic shift_en;
    logic wr_fire;
    logic wr_data;
    logic wr_status;
    logic wr_ctrl;
    logic wr_pins;
    logic strobe_wr;
    logic toggle_wr;
    logic sif_clr;
    logic oif_clr;
    logic pf_clr;
    logic collision;
    logic latch_open;
    logic [7:0] rd_val;
    logic rd_hit;
    logic wr_hit;

    function automatic logic usu_mapped(input logic [7:0] addr);
        usu_mapped = (addr == `USU_OFF_DATA) || (addr == `USU_OFF_STATUS) ||
                     (addr == `USU_OFF_CTRL) || (addr == `USU_OFF_PINS);
    endfunction

    // Pins cross from the bus side, so only synchronised copies are looked at
    usu_sync u_sync (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .async_in({pins_in.serial_in, pins_in.serial_clock}),
        .sync_out(pin_sync)
    );

    assign sda_s = pin_sync[1];
    assign scl_s = pin_sync[0];

    always_comb begin
        s_d = s_q;
        two_wire = (s_q.wm == `USU_WM_TWO);
        ext_clk = s_q.cs[1];
        // Edges come from the sampled pin; faster than a quarter of clk_in they are lost
        scl_rise = scl_s & ~s_q.scl_prev;
        scl_fall = ~scl_s & s_q.scl_prev;
        // One stage beyond the count, so the SDA edge trails synced SCL by the full delay
        sda_dly_now = s_q.sda_dly[`USU_SDA_DLY_CYC];
        sda_dly_old = s_q.sda_dly[`USU_SDA_DLY_CYC-1];
        // Delayed SDA edge is judged against live SCL, so SCL skew does not fake a start
        start_det = two_wire & scl_s & sda_dly_now & ~sda_dly_old;
        stop_det = two_wire & scl_s & ~sda_dly_now & sda_dly_old;
        s_d.scl_prev = scl_s;
        s_d.sda_dly = {s_q.sda_dly[`USU_SDA_DLY_CYC-1:0], sda_s};

        wr_fire = s_q.aw_got & s_q.w_got & ~s_q.axi.bvalid;
        wr_hit = usu_mapped(s_q.awaddr);
        wr_data = wr_fire & s_q.wlane & (s_q.awaddr == `USU_OFF_DATA);
        wr_status = wr_fire & s_q.wlane & (s_q.awaddr == `USU_OFF_STATUS);
        wr_ctrl = wr_fire & s_q.wlane & (s_q.awaddr == `USU_OFF_CTRL);
        wr_pins = wr_fire & s_q.wlane & (s_q.awaddr == `USU_OFF_PINS);
        strobe_wr = wr_ctrl & s_q.wdata[`USU_CT_STROBE];
        toggle_wr = wr_ctrl & s_q.wdata[`USU_CT_TOGGLE];
        sif_clr = wr_status & s_q.wdata[`USU_ST_SIF];
        oif_clr = wr_status & s_q.wdata[`USU_ST_OIF];
        pf_clr = wr_status & s_q.wdata[`USU_ST_PF];

        // Pin clock counts both edges, internal sources one per event
        if (ext_clk) begin
            cnt_inc = scl_rise | scl_fall;
            shift_en = s_q.cs[0] ? scl_fall : scl_rise;
        end else begin
            cnt_inc = s_q.cs[0] ? timer_match_in : strobe_wr;
            shift_en = cnt_inc;
        end

        if (wr_data) begin
            s_d.data = s_q.wdata;
        end else if (shift_en) begin
            s_d.data = {s_q.data[6:0], sda_s};
        end

        if (wr_status) begin
            s_d.cnt = s_q.wdata[`USU_ST_CNT_HI:`USU_ST_CNT_LO];
        end else if (cnt_inc) begin
            s_d.cnt = s_q.cnt + 4'h1;
        end

        // Flags: a start or stop set in the same cycle as a write-one clear wins; a status write drops counter sets
        if (sif_clr) begin
            s_d.sif = 1'b0;
        end
        if (two_wire ? start_det : (cnt_inc & ~wr_status)) begin
            s_d.sif = 1'b1;
        end
        if (oif_clr) begin
            s_d.oif = 1'b0;
        end
        if (cnt_inc & ~wr_status & (s_q.cnt == `USU_CNT_MAX)) begin
            s_d.oif = 1'b1;
        end
        if (pf_clr) begin
            s_d.pf = 1'b0;
        end
        if (stop_det) begin
            s_d.pf = 1'b1;
        end

        // Holds latch once SCL is low under a raised flag and drop with the flag
        s_d.shold = s_d.sif & two_wire & (s_q.shold | ~scl_s);
        s_d.ohold = s_d.oif & two_wire & (s_q.ohold | ~scl_s);

        if (wr_ctrl) begin
            s_d.sie = s_q.wdata[`USU_CT_SIE];
            s_d.oie = s_q.wdata[`USU_CT_OIE];
            s_d.wm = s_q.wdata[`USU_CT_WM_HI:`USU_CT_WM_LO];
            s_d.cs = s_q.wdata[`USU_CT_CS_HI:`USU_CT_CS_LO];
        end
        if (wr_pins) begin
            s_d.port_sda = s_q.wdata[`USU_PN_PORT_SDA];
            s_d.port_scl = s_q.wdata[`USU_PN_PORT_SCL];
            s_d.port_do = s_q.wdata[`USU_PN_PORT_DO];
            s_d.ddr_sda = s_q.wdata[`USU_PN_DDR_SDA];
            s_d.ddr_scl = s_q.wdata[`USU_PN_DDR_SCL];
            s_d.ddr_do = s_q.wdata[`USU_PN_DDR_DO];
        end
        if (toggle_wr) begin
            s_d.port_scl = ~s_q.port_scl;
        end

        // Open in the half cycle before the sampling edge, always open on internal clock
        latch_open = ~ext_clk | (scl_s == s_q.cs[0]);
        if (latch_open) begin
            s_d.latch = s_d.data[7];
        end

        s_d.pins.sda_out = 1'b0;
        s_d.pins.scl_out = 1'b0;
        s_d.pins.data_out = 1'b0;
        s_d.pins.sda_oe_n = 1'b1;
        s_d.pins.scl_oe_n = 1'b1;
        s_d.pins.data_oe_n = 1'b1;
        if (s_d.wm == `USU_WM_TWO) begin
            // Open drain: only low is driven; MSB or port bit pulls SDA down
            s_d.pins.sda_oe_n = ~(s_d.ddr_sda & (~s_d.latch | ~s_d.port_sda));
            s_d.pins.scl_oe_n = ~(s_d.ddr_scl &
                                  (~s_d.port_scl | s_d.shold | s_d.ohold));
        end else if (s_d.wm == `USU_WM_THREE) begin
            s_d.pins.data_out = s_d.latch;
            s_d.pins.data_oe_n = ~s_d.ddr_do;
            s_d.pins.scl_out = s_d.port_scl;
            s_d.pins.scl_oe_n = ~s_d.ddr_scl;
        end

        // Flag outputs are registered and change on the same clk_in edge as their flags
        s_d.start_irq = s_d.sif & s_d.sie;
        s_d.ovf_irq = s_d.oif & s_d.oie;

        collision = s_q.data[7] ^ sda_s;
        rd_hit = usu_mapped(axi_in.araddr[7:0]) & (axi_in.araddr[31:8] == 24'h000000);
        unique case (axi_in.araddr[7:0])
            `USU_OFF_DATA: rd_val = s_q.data;
            `USU_OFF_STATUS: rd_val = {s_q.sif, s_q.oif, s_q.pf, collision, s_q.cnt};
            `USU_OFF_CTRL: rd_val = {s_q.sie, s_q.oie, s_q.wm, s_q.cs, 2'h0};
            `USU_OFF_PINS: rd_val = {1'b0, s_q.ddr_do, s_q.ddr_scl, s_q.ddr_sda,
                                     1'b0, s_q.port_do, s_q.port_scl, s_q.port_sda};
            default: rd_val = 8'h00;
        endcase
        if (!rd_hit) begin
            rd_val = 8'h00;
        end

        // Write address and data are taken in either order, then answered once
        if (axi_in.awvalid & s_q.axi.awready) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = (axi_in.awaddr[31:8] == 24'h000000) ? axi_in.awaddr[7:0] : 8'hFF;
        end
        if (axi_in.wvalid & s_q.axi.wready) begin
            s_d.w_got = 1'b1;
            s_d.wdata = axi_in.wdata[7:0];
            s_d.wlane = axi_in.wstrb[0];
        end
        if (wr_fire) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.axi.bvalid = 1'b1;
            s_d.axi.bresp = wr_hit ? `USU_RESP_OKAY : `USU_RESP_SLVERR;
        end else if (s_q.axi.bvalid & axi_in.bready) begin
            s_d.axi.bvalid = 1'b0;
        end
        s_d.axi.awready = ~s_d.aw_got & ~s_d.axi.bvalid;
        s_d.axi.wready = ~s_d.w_got & ~s_d.axi.bvalid;

        if (axi_in.arvalid & s_q.axi.arready) begin
            s_d.axi.rvalid = 1'b1;
            s_d.axi.rdata = {24'h000000, rd_val};
            s_d.axi.rresp = rd_hit ? `USU_RESP_OKAY : `USU_RESP_SLVERR;
        end else if (s_q.axi.rvalid & axi_in.rready) begin
            s_d.axi.rvalid = 1'b0;
        end
        s_d.axi.arready = ~s_d.axi.rvalid;
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_q <= '0;
            s_q.data <= `USU_RST_DATA;
            s_q.cnt <= `USU_RST_CNT;
            s_q.scl_prev <= 1'b1;
            s_q.sda_dly <= '1;
            s_q.latch <= 1'b0;
            s_q.pins.sda_oe_n <= 1'b1;
            s_q.pins.scl_oe_n <= 1'b1;
            s_q.pins.data_oe_n <= 1'b1;
            s_q.axi.awready <= 1'b1;
            s_q.axi.wready <= 1'b1;
            s_q.axi.arready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Acknowledge handling and read termination are left to software
    assign axi_out = s_q.axi;
    assign pins_out = s_q.pins;
    assign start_irq_out = s_q.start_irq;
    assign ovf_irq_out = s_q.ovf_irq;
endmodule
`default_nettype wire

// ===== usu_props.sv
// Port-level assertion checker for the serial shift unit
`timescale 1ns/1ns
`default_nettype none
`include "usu_defines.svh"
module usu_props (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire usu_pkg::usu_axi_req_type axi_in,
    input wire usu_pkg::usu_axi_rsp_type axi_out,
    input wire usu_pkg::usu_pin_in_type pins_in,
    input wire usu_pkg::usu_pin_out_type pins_out,
    input wire logic timer_match_in,
    input wire logic start_irq_out,
    input wire logic ovf_irq_out
);
    import usu_pkg::*;
    logic wr_go;
    logic ar_go;
    logic [1:0] wm_q;
    logic ddr_do_q;
    logic [2:0] age_q;
    assign wr_go = axi_in.awvalid && axi_out.awready && axi_in.wvalid && axi_out.wready;
    assign ar_go = axi_in.arvalid && axi_out.arready;
    // Shadow of the mode and direction fields; it leads the design by one cycle
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wm_q <= 2'h0;
            ddr_do_q <= 1'b0;
            age_q <= 3'h7;
        end else begin
            age_q <= wr_go ? 3'h0 : age_q + {2'h0, age_q != 3'h7};
            if (wr_go && axi_in.wstrb[0] && axi_in.awaddr == {24'h0, `USU_OFF_CTRL}) begin
                wm_q <= axi_in.wdata[5:4];
            end
            if (wr_go && axi_in.wstrb[0] && axi_in.awaddr == {24'h0, `USU_OFF_PINS}) begin
                ddr_do_q <= axi_in.wdata[6];
            end
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);
    write_answer_a: assert property (wr_go |-> ##2 axi_out.bvalid)
        else $error("write response not on time");
    read_answer_a: assert property (ar_go |=> axi_out.rvalid)
        else $error("read response not on time");
    read_refuse_a: assert property (axi_out.rvalid |-> !axi_out.arready)
        else $error("read address taken while response pending");
    bad_addr_a: assert property (ar_go && axi_in.araddr[31:4] != 28'h0
        |=> axi_out.rresp == `USU_RESP_SLVERR)
        else $error("unmapped read not refused");
    mode_off_a: assert property (wm_q == 2'h0 [*4] |-> pins_out.scl_oe_n && pins_out.sda_oe_n)
        else $error("pin driven with no wire mode");
    open_drain_a: assert property (wm_q == 2'h2 [*4] |-> !pins_out.scl_out && !pins_out.sda_out)
        else $error("two-wire pin driven high");
    data_dir_a: assert property (!ddr_do_q [*4] |-> pins_out.data_oe_n)
        else $error("data pin driven without direction bit");
    start_clear_a: assert property ($fell(start_irq_out) |-> age_q < 3'h4)
        else $error("start flag cleared without a write");
    ovf_clear_a: assert property ($fell(ovf_irq_out) |-> age_q < 3'h4)
        else $error("overflow flag cleared without a write");
    start_seen_c: cover property ($rose(start_irq_out));
    ovf_seen_c: cover property ($rose(ovf_irq_out));
    bad_addr_c: cover property (ar_go && axi_in.araddr[31:4] != 28'h0);
endmodule
bind usu_top usu_props u_props (.clk_in(clk_in), .reset_n_in(reset_n_in), .axi_in(axi_in),
    .axi_out(axi_out), .pins_in(pins_in), .pins_out(pins_out), .timer_match_in(timer_match_in),
    .start_irq_out(start_irq_out), .ovf_irq_out(ovf_irq_out));
`default_nettype wire

// ===== usu_bus_model.sv
// Behavioural two-wire bus master on the far side of the serial pins
`timescale 1ns/1ns
`default_nettype none
module usu_bus_model (
    input wire logic sda_line_in,
    input wire logic scl_line_in,
    output logic sda_oe_n_out,
    output logic scl_oe_n_out
);
    // A quarter of a 160 ns bit time, far below a quarter of the system clock
    localparam int HALF = 40;
    logic last_sda;
    initial begin
        sda_oe_n_out <= 1'b1;
        scl_oe_n_out <= 1'b1;
        last_sda = 1'b1;
    end
    // Called on clock edges, so the lines move by non-blocking assignment
    task automatic set_lines(input logic sda, input logic scl);
        sda_oe_n_out <= sda;
        scl_oe_n_out <= scl;
        #HALF;
    endtask
    task automatic start_cond();
        set_lines(1'b0, 1'b1);
        #(3 * HALF);
        set_lines(1'b0, 1'b0);
    endtask
    task automatic stop_cond();
        set_lines(1'b0, 1'b1);
        set_lines(1'b1, 1'b1);
    endtask
    // The slave may stretch the clock, so wait for the line itself to rise
    task automatic send_bit(input logic b);
        int n;
        set_lines(b, 1'b0);
        // Data is set up longer than the slave's SDA delay, else a change looks like a start or a stop
        #HALF;
        scl_oe_n_out <= 1'b1;
        n = 0;
        while (!scl_line_in && n < 400) begin
            #8;
            n++;
        end
        #HALF;
        last_sda = sda_line_in;
        set_lines(b, 1'b0);
    endtask
endmodule
`default_nettype wire

// ===== tb_two_wire_serial_shifter.sv
// Self-checking bench for the serial shift unit
`timescale 1ns/1ns
`default_nettype none
`include "usu_defines.svh"
module tb_two_wire_serial_shifter;
    import usu_pkg::*;
    logic clk_in = 1'b0;
    logic reset_n_in;
    usu_axi_req_type req;
    usu_axi_rsp_type rsp;
    usu_pin_in_type pin;
    usu_pin_out_type pout;
    logic tmr;
    logic start_irq;
    logic ovf_irq;
    logic sda_n;
    logic scl_n;
    logic sda_line;
    logic scl_line;
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [33:0] exp_q[$];
    logic [7:0] d;
    logic [7:0] a;
    // Both lines have pull-ups; any party may pull low
    assign sda_line = sda_n & (pout.sda_oe_n | pout.sda_out);
    assign scl_line = scl_n & (pout.scl_oe_n | pout.scl_out);
    assign pin = {sda_line, scl_line};
    usu_top DUT (.clk_in(clk_in), .reset_n_in(reset_n_in), .axi_in(req), .axi_out(rsp),
        .pins_in(pin), .pins_out(pout), .timer_match_in(tmr), .start_irq_out(start_irq),
        .ovf_irq_out(ovf_irq));
    usu_bus_model bm (.sda_line_in(sda_line), .scl_line_in(scl_line), .sda_oe_n_out(sda_n),
        .scl_oe_n_out(scl_n));
    initial begin
        forever #4 clk_in = ~clk_in;
    end
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        if (n_mismatch == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    function automatic logic [33:0] ok8(input logic [7:0] v);
        return {26'h0, v};
    endfunction
    task automatic idle(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic wr(input logic [7:0] adr, input logic [7:0] v);
        logic done;
        done = 1'b0;
        exp_q.push_back(34'h0);
        @(posedge clk_in);
        req.awvalid <= 1'b1;
        req.awaddr <= {24'h0, adr};
        req.wvalid <= 1'b1;
        req.wdata <= {24'h0, v};
        req.wstrb <= 4'hF;
        req.bready <= 1'b1;
        while (!done) begin
            @(posedge clk_in);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) begin
                req.bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
    task automatic rd(input logic [7:0] adr, input logic [33:0] e);
        logic done;
        done = 1'b0;
        exp_q.push_back(e);
        @(posedge clk_in);
        req.arvalid <= 1'b1;
        req.araddr <= {24'h0, adr};
        req.rready <= 1'b1;
        while (!done) begin
            @(posedge clk_in);
            if (rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) begin
                req.rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
    // Each bus answer is matched against the oldest noted expectation
    always @(posedge clk_in) begin
        if (rsp.rvalid && req.rready) chk({rsp.rresp, rsp.rdata}, exp_q.pop_front());
        if (rsp.bvalid && req.bready) chk({rsp.bresp, 32'h0}, exp_q.pop_front());
    end
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
    initial begin
        req = '0;
        tmr = 1'b0;
        reset_n_in = 1'b0;
        void'($urandom(32'h426f));
        d = 8'($urandom());
        a = 8'($urandom());
        idle(12);
        reset_n_in <= 1'b1;
        idle(12);
        rd(`USU_OFF_DATA, ok8(8'h00));
        rd(`USU_OFF_STATUS, ok8(8'h10));
        rd(`USU_OFF_CTRL, ok8(8'h00));
        rd(`USU_OFF_PINS, ok8(8'h00));
        rd(8'h10, {2'h2, 32'h0});
        bm.start_cond();
        bm.stop_cond();
        idle(12);
        rd(`USU_OFF_STATUS, ok8(8'h10));
        wr(`USU_OFF_DATA, d);
        wr(`USU_OFF_CTRL, 8'h02);
        rd(`USU_OFF_DATA, ok8({d[6:0], 1'b1}));
        rd(`USU_OFF_STATUS, ok8({3'b100, ~d[6], 4'h1}));
        wr(`USU_OFF_CTRL, 8'h04);
        @(posedge clk_in);
        tmr <= 1'b1;
        @(posedge clk_in);
        tmr <= 1'b0;
        rd(`USU_OFF_DATA, ok8({d[5:0], 2'b11}));
        wr(`USU_OFF_STATUS, 8'hEF);
        wr(`USU_OFF_CTRL, 8'h48);
        bm.set_lines(1'b1, 1'b0);
        idle(12);
        chk({33'h0, ovf_irq}, 34'h1);
        bm.set_lines(1'b1, 1'b1);
        idle(12);
        rd(`USU_OFF_STATUS, ok8({3'b110, ~d[4], 4'h1}));
        wr(`USU_OFF_STATUS, 8'h01);
        rd(`USU_OFF_STATUS, ok8({3'b110, ~d[4], 4'h1}));
        wr(`USU_OFF_STATUS, 8'hC0);
        rd(`USU_OFF_STATUS, ok8({3'b000, ~d[4], 4'h0}));
        chk({33'h0, ovf_irq}, 34'h0);
        wr(`USU_OFF_PINS, 8'h40);
        wr(`USU_OFF_CTRL, 8'h10);
        wr(`USU_OFF_DATA, a);
        idle(4);
        chk({32'h0, pout.data_oe_n, pout.data_out}, {33'h0, a[7]});
        wr(`USU_OFF_PINS, 8'h00);
        idle(4);
        chk({33'h0, pout.data_oe_n}, 34'h1);
        // Slave receive: start, address byte, acknowledge, stop
        wr(`USU_OFF_DATA, 8'hFF);
        wr(`USU_OFF_PINS, 8'h22);
        wr(`USU_OFF_STATUS, 8'hE0);
        wr(`USU_OFF_CTRL, 8'hE8);
        bm.start_cond();
        idle(4);
        chk({33'h0, start_irq}, 34'h1);
        fork
            bm.send_bit(a[7]);
            begin
                idle(12);
                chk({33'h0, scl_line}, 34'h0);
                wr(`USU_OFF_STATUS, 8'h80);
            end
        join
        chk({33'h0, start_irq}, 34'h0);
        for (int i = 6; i >= 0; i--) begin
            bm.send_bit(a[i]);
        end
        idle(12);
        chk({33'h0, ovf_irq}, 34'h1);
        rd(`USU_OFF_DATA, ok8(a));
        rd(`USU_OFF_STATUS, ok8({3'b010, a[7] ^ a[0], 4'h0}));
        fork
            bm.send_bit(1'b1);
            begin
                idle(12);
                chk({33'h0, scl_line}, 34'h0);
                wr(`USU_OFF_PINS, 8'h32);
                // Acknowledge level must clear the SDA delay before SCL is let go
                idle(12);
                wr(`USU_OFF_STATUS, 8'h4E);
            end
        join
        chk({33'h0, bm.last_sda}, 34'h0);
        bm.set_lines(1'b0, 1'b0);
        fork
            bm.set_lines(1'b0, 1'b1);
            begin
                idle(12);
                chk({33'h0, scl_line}, 34'h0);
                wr(`USU_OFF_PINS, 8'h22);
                wr(`USU_OFF_STATUS, 8'h40);
            end
        join
        bm.set_lines(1'b1, 1'b1);
        idle(16);
        rd(`USU_OFF_STATUS, ok8({3'b001, ~a[5], 4'h1}));
        chk({33'h0, start_irq}, 34'h0);
        close_out();
    end
endmodule
`default_nettype wire
